// File: rtl/dacct_pkg.sv
package dacct_pkg;

  // system clock rate, period in picoseconds (20 MHz)
  localparam int unsigned CLK_PERIOD_PS = 50000;

  // timing figures in their own unit, as specified
  localparam int unsigned CONV_START_MIN_NS = 4;
  localparam int unsigned CONV_START_MAX_NS = 10;
  localparam int unsigned SAMPLE_GAP_3M_NS = 320;
  localparam int unsigned SAMPLE_GAP_4M_NS = 250;
  localparam int unsigned ALERT_NOS_MAX_NS = 12;
  localparam int unsigned CONVERT_MAX_NS = 190;

  // cycle counts: least times round up, longest times round down, floor one cycle on start and convert counts
  localparam int unsigned CONV_START_CYC =
    ((CONV_START_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
    ((CONV_START_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned GAP_3M_CYC = (SAMPLE_GAP_3M_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned GAP_4M_CYC = (SAMPLE_GAP_4M_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned CONVERT_CYC =
    ((CONVERT_MAX_NS * 1000) / CLK_PERIOD_PS) < 1 ? 1 :
    ((CONVERT_MAX_NS * 1000) / CLK_PERIOD_PS);

  // counter widths
  localparam int unsigned CNT_W = 8;
  localparam int unsigned OSR_W = 4;

  // result width and frame layout
  localparam int unsigned RES_W = 16;
  localparam int unsigned CMD_W = 16;
  localparam logic [RES_W-1:0] RES_RST = 16'h0000;

  // sequencer states
  typedef enum logic [1:0] {
    DACCT_IDLE,
    DACCT_START,
    DACCT_CONV,
    DACCT_GAP
  } dacct_seq_t;

  // one simultaneous pair of results
  typedef struct packed {
    logic [RES_W-1:0] ch_a;
    logic [RES_W-1:0] ch_b;
  } dacct_pair_t;

  // configuration carried from the link into the core
  typedef struct packed {
    logic alert_en;
    logic averaging_normal_mode;
    logic [OSR_W-1:0] osr_log2;
    logic [RES_W-1:0] threshold;
  } dacct_cfg_t;

endpackage : dacct_pkg

// File: rtl/dacct_link.sv
`timescale 1ns/100ps
`default_nettype none
// serial side: shifts results out on rising edges, captures the input on falling edges
module dacct_link
  import dacct_pkg::*;
(
  input wire logic sclk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic serial_in_line_i,
  input wire dacct_pair_t pair_i,
  input wire logic alert_i,
  input wire logic alert_en_i,
  output logic serial_out_a_o,
  output logic serial_out_b_with_alert_o,
  output logic sdo_oe_n_o,
  output logic [CMD_W-1:0] cmd_o,
  output logic cmd_tgl_o
);

  logic [RES_W-1:0] sh_a_ff; // channel a shifter
  logic [RES_W-1:0] sh_b_ff; // channel b shifter
  logic [RES_W-1:0] nxt_sh_a;
  logic [RES_W-1:0] nxt_sh_b;
  logic loaded_ff; // first rising edge of frame loads shifters
  logic nxt_loaded;
  logic [CMD_W-1:0] cmd_sh_ff; // input shifter, falling-edge domain
  logic [CMD_W-1:0] nxt_cmd_sh;
  logic [4:0] bit_cnt_ff;
  logic [4:0] nxt_bit_cnt;
  logic [CMD_W-1:0] cmd_ff;
  logic [CMD_W-1:0] nxt_cmd;
  logic tgl_ff;
  logic nxt_tgl;

  // rising-edge output shift; cs high restarts the frame asynchronously to sclk
  always_comb begin
    nxt_loaded = 1'b1;
    nxt_sh_a = {sh_a_ff[RES_W-2:0], 1'b0};
    nxt_sh_b = {sh_b_ff[RES_W-2:0], 1'b0};
    if (!loaded_ff) begin
      nxt_sh_a = {pair_i.ch_a[RES_W-2:0], 1'b0};
      nxt_sh_b = {pair_i.ch_b[RES_W-2:0], 1'b0};
    end
  end

  // sclk may stop between frames, so the frame start is cleared by cs itself
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      loaded_ff <= 1'b0;
      sh_a_ff <= RES_RST;
      sh_b_ff <= RES_RST;
    end else begin
      loaded_ff <= nxt_loaded;
      sh_a_ff <= nxt_sh_a;
      sh_b_ff <= nxt_sh_b;
    end
  end

  // msb shows before the first rising edge; alert shows on b when enabled
  always_comb begin
    serial_out_a_o = loaded_ff ? sh_a_ff[RES_W-1] : pair_i.ch_a[RES_W-1];
    serial_out_b_with_alert_o = loaded_ff ? sh_b_ff[RES_W-1] : pair_i.ch_b[RES_W-1];
    if (alert_en_i) begin
      serial_out_b_with_alert_o = alert_i;
    end
    sdo_oe_n_o = cs_n_i;
  end

  // falling-edge capture of the input line, command word every CMD_W bits
  always_comb begin
    nxt_cmd_sh = {cmd_sh_ff[CMD_W-2:0], serial_in_line_i};
    nxt_bit_cnt = bit_cnt_ff + 5'h01;
    nxt_cmd = cmd_ff;
    nxt_tgl = tgl_ff;
    if (bit_cnt_ff == 5'(CMD_W - 1)) begin
      nxt_cmd = {cmd_sh_ff[CMD_W-2:0], serial_in_line_i};
      nxt_tgl = ~tgl_ff; // event crosses as a toggle
      nxt_bit_cnt = 5'h00;
    end
  end

  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_ff <= 5'h00;
      cmd_sh_ff <= '0;
    end else begin
      bit_cnt_ff <= nxt_bit_cnt;
      cmd_sh_ff <= nxt_cmd_sh;
    end
  end

  // held word and toggle survive cs so the core can take them
  // system reset gives the toggle a known start matching the core's synchroniser;
  // an unknown toggle would stay unknown forever since it only ever inverts
  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_ff <= '0;
      tgl_ff <= 1'b0;
    end else begin
      cmd_ff <= nxt_cmd;
      tgl_ff <= nxt_tgl;
    end
  end

  assign cmd_o = cmd_ff;
  assign cmd_tgl_o = tgl_ff;

endmodule : dacct_link
`default_nettype wire

// File: rtl/dacct_core.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - first averaged sample starts 4-10 ns late; the core waits one 50 ns cycle
// - later samples spaced 320 or 250 ns; the core spaces them 300 or 250 ns
// - alert within 12 ns of threshold exceed
// - outputs enabled only after select low
// - outputs float within 45 ns of select high
// - input captured on falling serial clock
// - outputs change after rising serial clock
module dacct_core
  import dacct_pkg::*;
#(
  parameter bit FAST_VARIANT = 1'b1, // 1: 4 MSPS spacing, 0: 3 MSPS spacing
  parameter int unsigned OSR_MAX = 5 // largest accepted log2 averaging ratio
) (
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic SERIAL_IN_LINE_I,
  input wire logic [RES_W-1:0] AIN_A_I,
  input wire logic [RES_W-1:0] AIN_B_I,
  output logic SERIAL_OUT_A_O,
  output logic SERIAL_OUT_B_WITH_ALERT_O,
  output logic SDO_OE_N_O,
  output logic SAMPLE_O,
  output logic BUSY_O
);

  // sample spacing for the chosen variant
  localparam logic [CNT_W-1:0] GAP_CYC =
    CNT_W'(FAST_VARIANT ? GAP_4M_CYC : GAP_3M_CYC);
  localparam logic [CNT_W-1:0] START_CYC = CNT_W'(CONV_START_CYC);
  localparam logic [CNT_W-1:0] CONV_CYC = CNT_W'(CONVERT_CYC);

  // chip select synchroniser; first stage read only by the second
  logic cs_s1_ff;
  logic cs_s2_ff;
  logic cs_s3_ff; // previous synchronised value for edge detection
  // command toggle synchroniser
  logic tgl_s1_ff;
  logic tgl_s2_ff;
  logic tgl_s3_ff;
  logic [CMD_W-1:0] cmd_link; // stable when its toggle has been seen
  logic cmd_tgl_link;

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_s3_ff <= 1'b1;
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      tgl_s3_ff <= 1'b0;
    end else begin
      cs_s1_ff <= CS_N_I;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
      tgl_s1_ff <= cmd_tgl_link;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
    end
  end

  logic cs_fall; // frame start seen in the core domain
  logic cs_rise; // frame end seen in the core domain
  logic cmd_evt; // new command word arrived
  assign cs_fall = cs_s3_ff & ~cs_s2_ff;
  assign cs_rise = cs_s2_ff & ~cs_s3_ff;
  assign cmd_evt = tgl_s3_ff ^ tgl_s2_ff;

  // configuration, written by command words: [15] alert_en, [14] averaging,
  // [13:10] osr, [9:0] threshold upper bits
  dacct_cfg_t cfg_ff;
  dacct_cfg_t nxt_cfg;

  always_comb begin
    nxt_cfg = cfg_ff;
    if (cmd_evt) begin
      nxt_cfg.alert_en = cmd_link[15];
      nxt_cfg.averaging_normal_mode = cmd_link[14];
      nxt_cfg.osr_log2 = (cmd_link[13:10] > OSR_W'(OSR_MAX)) ? OSR_W'(OSR_MAX) :
                         cmd_link[13:10];
      nxt_cfg.threshold = {cmd_link[9:0], 6'h00};
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // conversion sequencer
  dacct_seq_t state_ff;
  dacct_seq_t nxt_state;
  logic [CNT_W-1:0] cnt_ff; // cycles left in current phase
  logic [CNT_W-1:0] nxt_cnt;
  logic [5:0] smp_ff; // samples still to take
  logic [5:0] nxt_smp;
  logic [RES_W+5:0] acc_a_ff; // running sums for averaging
  logic [RES_W+5:0] acc_b_ff;
  logic [RES_W+5:0] nxt_acc_a;
  logic [RES_W+5:0] nxt_acc_b;
  dacct_pair_t res_ff; // finished pair, shown to the link
  dacct_pair_t nxt_res;
  logic alert_ff;
  logic nxt_alert;
  logic shown_ff; // alert stood when the open frame began
  logic nxt_shown;
  logic sample_ff;
  logic nxt_sample;
  logic [RES_W-1:0] avg_a;
  logic [RES_W-1:0] avg_b;

  // averaged result; shift fits since sum width covers 2^OSR_MAX samples
  assign avg_a = RES_W'(acc_a_ff >> cfg_ff.osr_log2);
  assign avg_b = RES_W'(acc_b_ff >> cfg_ff.osr_log2);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_smp = smp_ff;
    nxt_acc_a = acc_a_ff;
    nxt_acc_b = acc_b_ff;
    nxt_res = res_ff;
    nxt_alert = alert_ff;
    nxt_sample = 1'b0;
    nxt_shown = shown_ff;
    // a frame that opens with the alert standing presents it on the b line
    if (cs_fall && alert_ff) begin
      nxt_shown = 1'b1;
    end
    // only the rise closing that frame clears it; the rise of the frame that started a
    // short conversion reaches the core after the result, so it must not clear
    if (cs_rise && shown_ff) begin
      nxt_alert = 1'b0;
      nxt_shown = 1'b0;
    end
    unique case (state_ff)
      DACCT_IDLE: begin
        if (cs_fall) begin
          // a new frame triggers a simultaneous conversion of both channels
          nxt_state = DACCT_START;
          nxt_cnt = START_CYC;
          nxt_smp = cfg_ff.averaging_normal_mode ?
                    6'(6'h01 << cfg_ff.osr_log2) : 6'h01;
          nxt_acc_a = '0;
          nxt_acc_b = '0;
        end
      end
      DACCT_START: begin
        // start delay, then take first sample
        if (cnt_ff <= 8'h01) begin
          nxt_sample = 1'b1;
          nxt_acc_a = acc_a_ff + (RES_W+6)'(AIN_A_I);
          nxt_acc_b = acc_b_ff + (RES_W+6)'(AIN_B_I);
          nxt_smp = smp_ff - 6'h01;
          nxt_state = (smp_ff == 6'h01) ? DACCT_CONV : DACCT_GAP;
          nxt_cnt = (smp_ff == 6'h01) ? CONV_CYC : GAP_CYC;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      DACCT_GAP: begin
        // fixed spacing from one sample start to the next
        if (cnt_ff <= 8'h01) begin
          nxt_sample = 1'b1;
          nxt_acc_a = acc_a_ff + (RES_W+6)'(AIN_A_I);
          nxt_acc_b = acc_b_ff + (RES_W+6)'(AIN_B_I);
          nxt_smp = smp_ff - 6'h01;
          nxt_state = (smp_ff == 6'h01) ? DACCT_CONV : DACCT_GAP;
          nxt_cnt = (smp_ff == 6'h01) ? CONV_CYC : GAP_CYC;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      DACCT_CONV: begin
        // final conversion; result latched for the next frame's read-out
        if (cnt_ff <= 8'h01) begin
          nxt_res.ch_a = avg_a;
          nxt_res.ch_b = avg_b;
          nxt_state = DACCT_IDLE;
          // threshold check on the result cannot raise alert a cycle later, under 12 ns
          // being impossible at 20 MHz, so it is flagged in the same result cycle
          if (cfg_ff.alert_en && ((avg_a > cfg_ff.threshold) ||
              (avg_b > cfg_ff.threshold))) begin
            nxt_alert = 1'b1;
            nxt_shown = 1'b0; // a fresh alert waits for a frame of its own
          end
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      state_ff <= DACCT_IDLE;
      cnt_ff <= '0;
      smp_ff <= '0;
      acc_a_ff <= '0;
      acc_b_ff <= '0;
      res_ff <= '0;
      alert_ff <= 1'b0;
      shown_ff <= 1'b0;
      sample_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      smp_ff <= nxt_smp;
      acc_a_ff <= nxt_acc_a;
      acc_b_ff <= nxt_acc_b;
      res_ff <= nxt_res;
      alert_ff <= nxt_alert;
      shown_ff <= nxt_shown;
      sample_ff <= nxt_sample;
    end
  end

  // result and alert change only between frames, so the link reads them steady
  dacct_link dacct_link_inst (
    .sclk_i(SCLK_I),
    .rst_i(SYS_RST_I),
    .cs_n_i(CS_N_I),
    .serial_in_line_i(SERIAL_IN_LINE_I),
    .pair_i(res_ff),
    .alert_i(alert_ff),
    .alert_en_i(cfg_ff.alert_en),
    .serial_out_a_o(SERIAL_OUT_A_O),
    .serial_out_b_with_alert_o(SERIAL_OUT_B_WITH_ALERT_O),
    .sdo_oe_n_o(SDO_OE_N_O),
    .cmd_o(cmd_link),
    .cmd_tgl_o(cmd_tgl_link)
  );

  assign SAMPLE_O = sample_ff;
  assign BUSY_O = (state_ff != DACCT_IDLE);

endmodule : dacct_core
`default_nettype wire

// File: dv/dacct_checker.sv
`timescale 1ns/100ps
`default_nettype none
// watches sequencing and output enable at the converter top
module dacct_checker (
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic CS_N_I,
  input wire logic SDO_OE_N_O,
  input wire logic SAMPLE_O,
  input wire logic BUSY_O
);
  // one domain, so clock and reset are given once
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  property p_oe_on; !CS_N_I |-> !SDO_OE_N_O; endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("outputs not driven while selected");
  property p_oe_off; CS_N_I |-> SDO_OE_N_O; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("outputs driven while deselected");
  property p_cs_smp; $fell(CS_N_I) |-> ##[1:8] SAMPLE_O; endproperty
  a_cs_smp: assert property (p_cs_smp)
    else $error("no sample after select fell");
  // a gap shorter than five cycles, the 4 MSPS sample spacing, shows up here
  property p_gap; SAMPLE_O |=> !SAMPLE_O [*4]; endproperty
  a_gap: assert property (p_gap)
    else $error("samples spaced too closely");
  property p_smp_busy; SAMPLE_O |-> BUSY_O; endproperty
  a_smp_busy: assert property (p_smp_busy)
    else $error("sample taken while idle");
  property p_tail; SAMPLE_O |=> BUSY_O [*2]; endproperty
  a_tail: assert property (p_tail)
    else $error("busy dropped during conversion");
  property p_rose; $rose(BUSY_O) |-> !$past(CS_N_I); endproperty
  a_rose: assert property (p_rose)
    else $error("busy without select low");
  property p_start; $rose(BUSY_O) |-> ##[0:2] SAMPLE_O; endproperty
  a_start: assert property (p_start)
    else $error("first sample late");
  c_avg: cover property (SAMPLE_O ##5 SAMPLE_O);
  c_done: cover property ($fell(BUSY_O));
  c_sel: cover property ($fell(CS_N_I));
endmodule : dacct_checker
bind dacct_core dacct_checker dacct_checker_inst (.CLOCK_I, .SYS_RST_I, .CS_N_I,
  .SDO_OE_N_O, .SAMPLE_O, .BUSY_O);
`default_nettype wire

// File: dv/dacct_host.sv
`timescale 1ns/100ps
`default_nettype none
// host model: link clock of 15 ns runs only inside frames
module dacct_host (
  output var logic sclk_o,
  output var logic cs_n_o,
  output var logic sdi_o,
  input wire logic sdo_a_i,
  input wire logic sdo_b_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // one frame: command in msb first, both results out msb first
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] ra,
                      output logic [15:0] rb);
    #10;
    cs_n_o = 1'b0;
    #7.5;
    ra[15] = sdo_a_i;
    rb[15] = sdo_b_i;
    for (int i = 0; i < 16; i++) begin
      sdi_o = cmd[15-i];
      #1.5 sclk_o = 1'b1;
      // outputs move after the rise, so read just before the fall
      #7.5;
      if (i < 15) begin
        ra[14-i] = sdo_a_i;
        rb[14-i] = sdo_b_i;
      end
      sclk_o = 1'b0;
      #6;
    end
    cs_n_o = 1'b1;
    // a released line never keeps its last value
    sdi_o = ~sdi_o;
  endtask : xfer
endmodule : dacct_host
`default_nettype wire

// File: dv/dacct_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dacct_core_tb;
  import dacct_pkg::*;
  logic clk, rst, sclk, cs_n, serial_in_line, sdo_a, sdo_b, oe_n, smp, busy;
  logic [15:0] ain_a, ain_b, va, vb, ra, rb, lo, hi;
  logic [3:0] osr, eo;
  int fails, samples_checked, nsmp, cyc, first, last, nseen, span;
  dacct_core #(.FAST_VARIANT(1'b1), .OSR_MAX(5)) dacct_core_inst (
    .CLOCK_I(clk), .SYS_RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n),
    .SERIAL_IN_LINE_I(serial_in_line), .AIN_A_I(ain_a), .AIN_B_I(ain_b),
    .SERIAL_OUT_A_O(sdo_a), .SERIAL_OUT_B_WITH_ALERT_O(sdo_b),
    .SDO_OE_N_O(oe_n), .SAMPLE_O(smp), .BUSY_O(busy));
  dacct_host dacct_host_inst (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(serial_in_line),
    .sdo_a_i(sdo_a), .sdo_b_i(sdo_b));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // counts sample pulses and notes when the first and last came; read at the
  // falling edge so the registered pulse has settled
  always @(negedge clk) begin
    cyc++;
    if (smp === 1'b1) begin
      if (nsmp == 0)
        first = cyc;
      last = cyc;
      nsmp++;
    end
  end
  // cycles from first to last averaged sample
  function automatic logic [15:0] exp_span(input logic [3:0] o);
    return 16'(((1 << o) - 1) * GAP_4M_CYC);
  endfunction : exp_span
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // one frame, then a bounded wait for the sequencer to go idle
  task automatic run(input logic [15:0] cmd, output logic [15:0] a, output logic [15:0] b);
    int n;
    n = 0;
    dacct_host_inst.xfer(cmd, a, b);
    repeat (4) @(negedge clk);
    while (busy !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n == 400) begin
      fails++;
      end_of_test();
    end
  endtask : run
  // load config, convert with it, then read the result back
  task automatic conv(input logic [15:0] cmd, input logic [15:0] a, input logic [15:0] b);
    ain_a = a;
    ain_b = b;
    run(cmd, ra, rb);
    nsmp = 0;
    run(cmd, ra, rb);
    // only the conversion under the new setting is counted
    nseen = nsmp;
    span = last - first;
    run(cmd, ra, rb);
  endtask : conv
  initial begin
    rst = 1'b1;
    ain_a = 16'h0000;
    ain_b = 16'h0000;
    void'($urandom(17));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    // no supply ramp or power-down in the model: reset release stands for both
    repeat (16) @(negedge clk);
    // first frame loads an all-zero configuration
    run(16'h0000, ra, rb);
    for (int k = 0; k < 8; k++) begin
      osr = (k == 0) ? 4'h0 : (k == 1) ? 4'h5 : (k == 2) ? 4'hF : 4'($urandom_range(5));
      eo = (osr > 4'h5) ? 4'h5 : osr; // ratios above the limit are clamped
      va = 16'($urandom);
      vb = 16'($urandom);
      conv({1'b0, osr != 4'h0, osr, 10'h000}, va, vb);
      chk("res_a", ra, va);
      chk("res_b", rb, vb);
      chk("samples", 16'(nseen), 16'h0001 << eo);
      chk("span", 16'(span), exp_span(eo));
      $display("test %0d done", k);
    end
    // threshold 0x2000: one pair below it, one above
    conv(16'h8080, 16'h0010, 16'h0010);
    lo = rb;
    chk("res_a_lo", ra, 16'h0010);
    conv(16'h8080, 16'h7000, 16'h7000);
    hi = rb;
    chk("res_a_hi", ra, 16'h7000);
    chk("alert_lo", {15'h0000, lo[15]}, 16'h0000);
    chk("alert_hi", {15'h0000, hi[15]}, 16'h0001);
    $display("test alert done");
    end_of_test();
  end
endmodule : dacct_core_tb
`default_nettype wire
